// *** core/isolated_ttl_dio_port.sv ***
/*
 byte-wide isolated and ttl digital i/o port with edge interrupt.
 assumes bus strobes and field inputs are synchronous to CLK.
*/
`timescale 1ns/100ps
module isolated_ttl_dio_port
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // host i/o bus
   input wire logic [dio_port_pkg::ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic IOW,
   input wire logic IOR,
   output logic [7:0] RDATA,
   output logic SELECTED,
   // board straps
   input wire logic [dio_port_pkg::SEL_W-1:0] BASE_SELECT_SWITCH,
   input wire logic [1:0] IRQ_SOURCE_JUMPER,
   input wire logic IRQ_EDGE_JUMPER,
   input wire logic IRQ_LINE_JUMPER,
   // field channels
   output logic [7:0] ISOLATED_OUTPUT_CHANNEL,
   input wire logic [7:0] ISOLATED_INPUT_CHANNEL,
   output logic [15:0] TTL_OUTPUT_CHANNEL,
   input wire logic [15:0] TTL_INPUT_CHANNEL,
   // interrupt
   output logic IRQ
);
   import dio_port_pkg::*;
   // ******************************************
   // address decode
   // ******************************************
   logic [ADDR_W-1:0] base_addr; // full base byte address
   logic [ADDR_W-1:0] offset; // distance from base
   logic in_window; // address within claimed bytes
   logic [3:0] ofs; // low offset nibble
   logic [7:0] iso_ff; // isolated output latch
   logic [15:0] ttl_ff; // ttl output latch
   logic [7:0] rdata_ff; // read data register
   logic sel_ff; // claim indication
   logic src_ff; // previous source level
   logic irq_ff; // interrupt pulse register
   logic src_now; // selected source level
   logic fire; // selected edge seen

   // switch value forms a9..a4; a9 is forced so the range stays 0x200..0x3F0
   assign base_addr = {BASE_SELECT_SWITCH | SEL_MIN, 4'h0};
   // the subtraction wraps below base; the first compare keeps that out
   assign offset = ADDR - base_addr;
   assign in_window = (ADDR >= base_addr) && (offset < {6'h00, WINDOW_SPAN});
   assign ofs = offset[3:0];

   // ******************************************
   // output latches
   // ******************************************
   // writes land one clock after the strobe is seen
   always_ff @(posedge CLK) begin
      if (RST) begin
         iso_ff <= OUT_RESET;
         ttl_ff <= {OUT_RESET, OUT_RESET};
      end else if (IOW && in_window) begin
         if (ofs == OFS_ISO) begin
            iso_ff <= WDATA;
         end else if (ofs == OFS_TTL_LO) begin
            ttl_ff[7:0] <= WDATA;
         end else if (ofs == OFS_TTL_HI) begin
            ttl_ff[15:8] <= WDATA;
         end
         // offset one and upper slots: write ignored
      end
   end
   // outputs come straight from the latches, so no decode glitch reaches a pin
   assign ISOLATED_OUTPUT_CHANNEL = iso_ff;
   assign TTL_OUTPUT_CHANNEL = ttl_ff;

   // ******************************************
   // read path
   // ******************************************
   // read data registered, so it trails the strobe by one clock
   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_ff <= RSVD_READ;
         sel_ff <= 1'b0;
      end else begin
         sel_ff <= (IOR || IOW) && in_window;
         if (IOR && in_window && ofs == OFS_ISO) begin
            rdata_ff <= ISOLATED_INPUT_CHANNEL;
         end else if (IOR && in_window && ofs == OFS_TTL_LO) begin
            rdata_ff <= TTL_INPUT_CHANNEL[7:0];
         end else if (IOR && in_window && ofs == OFS_TTL_HI) begin
            rdata_ff <= TTL_INPUT_CHANNEL[15:8];
         end else begin
            rdata_ff <= RSVD_READ; // offset one and spares read zero
         end
      end
   end
   // spare slots and idle cycles read zero, so a stray read is harmless
   assign RDATA = rdata_ff;
   assign SELECTED = sel_ff;

   // ******************************************
   // edge interrupt
   // ******************************************
   // source picked by the jumper; only the chosen channel can interrupt
   always_comb begin
      case (IRQ_SOURCE_JUMPER)
         SRC_ISO0: src_now = ISOLATED_INPUT_CHANNEL[0];
         SRC_ISO1: src_now = ISOLATED_INPUT_CHANNEL[1];
         SRC_TTL0: src_now = TTL_INPUT_CHANNEL[0];
         default: src_now = TTL_INPUT_CHANNEL[1];
      endcase
   end
   // edge seen between the previous clock and this one
   assign fire = (IRQ_EDGE_JUMPER == EDGE_RISE) ? (src_now && !src_ff)
      : (!src_now && src_ff);

   // one-clock pulse; the line jumper disables the interrupt entirely
   always_ff @(posedge CLK) begin
      if (RST) begin
         // loaded from the source so a high input at release is not taken as an edge
         src_ff <= src_now;
         irq_ff <= 1'b0;
      end else begin
         src_ff <= src_now;
         irq_ff <= fire && IRQ_LINE_JUMPER;
      end
   end
   assign IRQ = irq_ff;

   // ******************************************
   // assertions
   // ******************************************
   // strobes that land inside the claimed window, one for each of offsets 0 to 3
   sequence s_write_iso;
      IOW && in_window && ofs == OFS_ISO;
   endsequence
   sequence s_write_ttl_lo;
      IOW && in_window && ofs == OFS_TTL_LO;
   endsequence
   sequence s_write_ttl_hi;
      IOW && in_window && ofs == OFS_TTL_HI;
   endsequence
   sequence s_write_unused;
      IOW && in_window && ofs == OFS_UNUSED;
   endsequence
   // the selected source moved in the jumpered direction with the line enabled
   sequence s_armed_edge;
      IRQ_LINE_JUMPER && src_now != $past(src_now)
         && src_now == (IRQ_EDGE_JUMPER == EDGE_RISE);
   endsequence

   // a write reaches its latch on the next clock
   AST_ISO_WRITE: assert property (@(posedge CLK) disable iff (RST)
      s_write_iso |=> ISOLATED_OUTPUT_CHANNEL == $past(WDATA)) else $error("iso write lost");
   // low ttl byte only; the high byte keeps its value
   AST_TTL_LO: assert property (@(posedge CLK) disable iff (RST)
      s_write_ttl_lo |=> TTL_OUTPUT_CHANNEL == {$past(TTL_OUTPUT_CHANNEL[15:8]), $past(WDATA)})
      else $error("ttl low write lost");
   AST_TTL_HI: assert property (@(posedge CLK) disable iff (RST)
      s_write_ttl_hi |=> TTL_OUTPUT_CHANNEL == {$past(WDATA), $past(TTL_OUTPUT_CHANNEL[7:0])})
      else $error("ttl high write lost");
   // with no write strobe the latches keep what software last wrote
   AST_HOLD: assert property (@(posedge CLK) disable iff (RST)
      !IOW |=> $stable(ISOLATED_OUTPUT_CHANNEL) && $stable(TTL_OUTPUT_CHANNEL))
      else $error("outputs moved without write");
   // the dead slot swallows writes
   AST_UNUSED_WRITE: assert property (@(posedge CLK) disable iff (RST)
      s_write_unused |=> $stable(ISOLATED_OUTPUT_CHANNEL) && $stable(TTL_OUTPUT_CHANNEL))
      else $error("dead slot write reached an output");
   // reads return the levels seen at the strobe clock
   AST_READ_ISO: assert property (@(posedge CLK) disable iff (RST)
      IOR && in_window && ofs == OFS_ISO |=> RDATA == $past(ISOLATED_INPUT_CHANNEL))
      else $error("iso read wrong");
   AST_READ_TTL_LO: assert property (@(posedge CLK) disable iff (RST)
      IOR && in_window && ofs == OFS_TTL_LO |=> RDATA == $past(TTL_INPUT_CHANNEL[7:0]))
      else $error("ttl low read wrong");
   AST_READ_TTL_HI: assert property (@(posedge CLK) disable iff (RST)
      IOR && in_window && ofs == OFS_TTL_HI |=> RDATA == $past(TTL_INPUT_CHANNEL[15:8]))
      else $error("ttl high read wrong");
   // the dead slot is claimed but reads as zero
   AST_READ_UNUSED: assert property (@(posedge CLK) disable iff (RST)
      IOR && in_window && ofs == OFS_UNUSED |=> RDATA == RSVD_READ && SELECTED)
      else $error("unused slot not claimed or not zero");
   // every strobe inside the nine bytes is claimed
   AST_SEL_WINDOW: assert property (@(posedge CLK) disable iff (RST)
      (IOR || IOW) && in_window |=> SELECTED) else $error("window strobe not claimed");
   // nothing below the base or past the ninth byte is claimed
   AST_OUTSIDE: assert property (@(posedge CLK) disable iff (RST)
      ADDR < base_addr |=> !SELECTED) else $error("claimed below base");
   AST_ABOVE: assert property (@(posedge CLK) disable iff (RST)
      ADDR >= base_addr + 10'h009 |=> !SELECTED) else $error("claimed past window");
   // reset clears the latches and silences the bus side
   AST_RESET_OFF: assert property (@(posedge CLK)
      RST |=> ISOLATED_OUTPUT_CHANNEL == OUT_RESET && TTL_OUTPUT_CHANNEL == 16'h0000)
      else $error("outputs not off after reset");
   AST_RESET_QUIET: assert property (@(posedge CLK)
      RST |=> !SELECTED && !IRQ && RDATA == RSVD_READ)
      else $error("bus side busy after reset");
   // an interrupt pulse only follows an armed edge of the jumpered source
   AST_IRQ: assert property (@(posedge CLK) disable iff (RST)
      IRQ |-> $past(IRQ_LINE_JUMPER) && $past(src_now) != $past(src_now, 2)
         && $past(src_now) == ($past(IRQ_EDGE_JUMPER) == EDGE_RISE))
      else $error("irq without edge");
   // and every armed edge gives one on the next clock
   AST_IRQ_FIRE: assert property (@(posedge CLK) disable iff (RST)
      s_armed_edge |=> IRQ) else $error("armed edge gave no irq");
   // the disabled line position keeps the interrupt quiet
   AST_IRQ_MUTED: assert property (@(posedge CLK) disable iff (RST)
      !IRQ_LINE_JUMPER |=> !IRQ) else $error("irq while line disabled");
endmodule // isolated_ttl_dio_port

// *** core/dio_port_pkg.sv ***
/*
 constants for the isolated and ttl digital i/o port block.
 assumes a byte-wide i/o bus with ten address lines, decoded in one clock.
*/
package dio_port_pkg;
   // ******************************************
   // address decode
   // ******************************************
   localparam int ADDR_W = 10;               // i/o address lines a9..a0
   localparam int SEL_W = 6;                 // switch compares a9..a4
   localparam int SEL_LSB = 4;               // lowest compared line
   localparam logic [SEL_W-1:0] SEL_DEFAULT = 6'h30; // base 0x300
   localparam logic [SEL_W-1:0] SEL_MIN = 6'h20;     // base 0x200
   localparam logic [3:0] WINDOW_SPAN = 4'h9;        // claimed bytes
   // ******************************************
   // register offsets
   // ******************************************
   localparam logic [3:0] OFS_ISO = 4'h0;    // isolated_io_data
   localparam logic [3:0] OFS_UNUSED = 4'h1; // unused_slot
   localparam logic [3:0] OFS_TTL_LO = 4'h2; // ttl_io_low_byte
   localparam logic [3:0] OFS_TTL_HI = 4'h3; // ttl_io_high_byte
   // ******************************************
   // reset values and interrupt encodings
   // ******************************************
   localparam logic [7:0] OUT_RESET = 8'h00; // outputs off
   localparam logic [7:0] RSVD_READ = 8'h00; // reserved slots read zero
   localparam logic [1:0] SRC_ISO0 = 2'h0;   // isolated input 0
   localparam logic [1:0] SRC_ISO1 = 2'h1;   // isolated input 1
   localparam logic [1:0] SRC_TTL0 = 2'h2;   // ttl input 0
   localparam logic [1:0] SRC_TTL1 = 2'h3;   // ttl input 1
   localparam logic EDGE_RISE = 1'h0;        // default trigger edge
endpackage

// *** bench/host_bus_model.sv ***
/*
 host i/o bus model: one byte write or read, one strobe cycle each.
 assumes the port answers on RDATA the cycle after the strobe.
*/
`timescale 1ns/100ps
module host_bus_model (
   // bus
   input wire logic CLK,
   input wire logic [7:0] RDATA,
   output logic [9:0] ADDR,
   output logic [7:0] WDATA,
   output logic IOW,
   output logic IOR
);
   initial begin
      {ADDR, WDATA, IOW, IOR} = 20'h00000;
   end
   // strobe held to the taking edge, then junk on the lines so stale values cannot pass
   task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic w);
      @(posedge CLK);
      {ADDR, WDATA, IOW, IOR} <= {a, d, w, !w};
      @(posedge CLK);
      {ADDR, WDATA, IOW, IOR} <= {~a, ~d, 2'h0};
      #1;
   endtask
   // read: one strobe cycle, then the registered answer is taken once settled
   task automatic rd(input logic [9:0] a, output logic [7:0] q);
      cyc(a, 8'h00, 1'b0);
      q = RDATA;
   endtask
endmodule // host_bus_model

// *** bench/isolated_ttl_dio_port_test.sv ***
/*
 self-checking bench for the digital i/o port block.
 assumes host_bus_model drives the bus; field inputs come from here.
*/
`timescale 1ns/100ps
module isolated_ttl_dio_port_test;
   import dio_port_pkg::*;
   logic clk, rst, iow, ior, sel, irq, edge_j, line_j;
   logic [9:0] addr;
   logic [7:0] wdata, rdata, iso_out, iso_in;
   logic [15:0] ttl_out, ttl_in;
   logic [5:0] sw;
   logic [1:0] src;
   int num_errors = 0, num_checks = 0, cnt;
   logic [9:0] ra [6] = '{10'h300, 10'h302, 10'h303, 10'h301, 10'h308, 10'h309};
   logic [7:0] re [6];
   logic [7:0] got;
   // source, line, edge, new level; each step leaves the next source free of a false edge
   logic [4:0] ic [6] = '{5'b10101, 5'b10110, 5'b10001, 5'b00101, 5'b01101, 5'b11110};
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   host_bus_model u_host (.CLK(clk), .RDATA(rdata), .ADDR(addr), .WDATA(wdata),
      .IOW(iow), .IOR(ior));
   isolated_ttl_dio_port u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .IOW(iow), .IOR(ior), .RDATA(rdata), .SELECTED(sel), .BASE_SELECT_SWITCH(sw),
      .IRQ_SOURCE_JUMPER(src), .IRQ_EDGE_JUMPER(edge_j), .IRQ_LINE_JUMPER(line_j),
      .ISOLATED_OUTPUT_CHANNEL(iso_out), .ISOLATED_INPUT_CHANNEL(iso_in),
      .TTL_OUTPUT_CHANNEL(ttl_out), .TTL_INPUT_CHANNEL(ttl_in), .IRQ(irq));
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #20000;
      num_errors++;
      print_verdict();
   end
   initial begin
      {rst, sw, src, edge_j, line_j} = {1'b1, SEL_DEFAULT, SRC_TTL0, EDGE_RISE, 1'b1};
      {iso_in, ttl_in} = 24'h3C9A76;
      re = '{8'h3C, 8'h76, 8'h9A, RSVD_READ, RSVD_READ, 8'h00};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1 chk("out after reset", {iso_out, ttl_out}, 24'h000000);
      u_host.cyc(10'h300, 8'hA5, 1'b1);
      chk("iso out", 24'(iso_out), 24'h0000A5);
      u_host.cyc(10'h302, 8'h5A, 1'b1);
      u_host.cyc(10'h303, 8'hC3, 1'b1);
      chk("ttl out", 24'(ttl_out), 24'h00C35A);
      u_host.cyc(10'h301, 8'hFF, 1'b1);
      chk("dead slot write", {iso_out, ttl_out}, 24'hA5C35A);
      // a reset in mid-run must turn every lit output off again
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk("out after mid reset", {iso_out, ttl_out}, 24'h000000);
      $display("test writes done");
      for (int i = 0; i < 6; i++) begin
         u_host.rd(ra[i], got);
         chk("read data", 24'(got), 24'(re[i]));
         chk("selected", 24'(sel), 24'(i < 5));
      end
      $display("test reads done");
      @(posedge clk) sw <= SEL_MIN;
      u_host.cyc(10'h200, 8'h0F, 1'b1);
      u_host.cyc(10'h300, 8'hFF, 1'b1);
      chk("moved base", 24'(iso_out), 24'h00000F);
      @(posedge clk) sw <= 6'h3F;
      u_host.cyc(10'h3F3, 8'h81, 1'b1);
      chk("top base", 24'(ttl_out), 24'h008100);
      $display("test base done");
      foreach (ic[k]) begin
         cnt = 0;
         // jumpers settle a clock before the source moves
         @(posedge clk) {src, line_j, edge_j} <= ic[k][4:1];
         @(posedge clk);
         case (ic[k][4:3])
            SRC_ISO0: iso_in[0] <= ic[k][0];
            SRC_ISO1: iso_in[1] <= ic[k][0];
            SRC_TTL0: ttl_in[0] <= ic[k][0];
            default: ttl_in[1] <= ic[k][0];
         endcase
         repeat (4) @(posedge clk) #1 cnt += (irq === 1'b1);
         chk("irq pulses", 24'(cnt), 24'(ic[k][2]));
      end
      $display("test irq done");
      print_verdict();
   end
endmodule // isolated_ttl_dio_port_test
